// [rtl/aste_pkg.sv]
// Constants and types for the analog-input sample timing engine.
package aste_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_CHANS = 8'h0C;
  localparam logic [7:0] ADDR_PRE = 8'h10;
  localparam logic [7:0] ADDR_POST = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [7:0] ADDR_COUNT = 8'h24;

  // Control register bits; bits 0 and 1 are self-clearing commands.
  localparam int CTRL_SW_START = 0;
  localparam int CTRL_SW_TICK = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_PRETRIG = 3;
  localparam int CTRL_FALLING = 4;
  localparam int CTRL_HW_START = 5;
  localparam int CTRL_ABORT = 6;

  // Status bits.
  localparam int STAT_DONE = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_REF_ACC = 2;
  localparam int STAT_W = 3;

  localparam logic [31:0] RESET_DIV = 32'h0000_0001;
  localparam logic [7:0] RESET_CHANS = 8'h01;

  // Source selection codes for the scan tick.
  typedef enum logic [1:0] {
    ASTE_SRC_COUNTER = 2'b00,
    ASTE_SRC_DIVIDER = 2'b01,
    ASTE_SRC_SOFTWARE = 2'b10,
    ASTE_SRC_EXTERNAL = 2'b11
  } aste_src_e;

  // Acquisition phases.
  typedef enum logic [1:0] {
    ASTE_IDLE = 2'b00,
    ASTE_PRE = 2'b01,
    ASTE_WAIT_REF = 2'b10,
    ASTE_POST = 2'b11
  } aste_phase_e;

  // External terminal bundle.
  typedef struct packed {
    logic [5:0] programmable_function_pins;
    logic [7:0] chassis_sync_lines;
    logic star_trigger_line;
  } aste_ext_s;

  // Source select register layout: kind and external line number.
  typedef struct packed {
    logic [3:0] ext_line;
    aste_src_e kind;
  } aste_srcsel_s;

  localparam int EXT_LINES = 15;

endpackage : aste_pkg

// [rtl/aste_timing_engine.sv]
// Analog-input sample timing engine with register port and interrupt.
`timescale 1ns/1ps
module aste_timing_engine (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire aste_pkg::aste_ext_s ext_in,
  input wire logic counter_out,
  input wire logic scan_timebase,
  input wire logic channel_conversion_tick,
  input wire logic acq_begin_trigger,
  input wire logic capture_ref_trigger,
  input wire logic acq_hold_trigger,
  output logic acq_begin_trigger_out,
  output logic convert_start,
  output logic sample_start,
  output logic acq_active,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [6:2] ctrl_q;
  aste_pkg::aste_srcsel_s src_q;
  logic [31:0] div_q;
  logic [7:0] chans_q;
  logic [31:0] pre_q;
  logic [31:0] post_q;
  logic [aste_pkg::STAT_W-1:0] stat_q;
  logic [aste_pkg::STAT_W-1:0] mask_q;
  logic sw_start_q;
  logic sw_tick_q;
  aste_pkg::aste_phase_e phase_q;
  logic [31:0] count_q;
  logic [7:0] conv_left_q;
  logic [31:0] div_cnt_q;
  logic raw_q;
  logic tb_q;
  logic div_tick;
  logic raw_tick;
  logic edge_tick;
  logic tick_ok;
  logic conv_ok;
  logic start_ev;
  logic busy;
  logic last_sample;
  logic [aste_pkg::STAT_W-1:0] stat_set;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= '0;
      src_q <= '0;
      div_q <= aste_pkg::RESET_DIV;
      chans_q <= aste_pkg::RESET_CHANS;
      pre_q <= '0;
      post_q <= '0;
      mask_q <= '0;
      sw_start_q <= 1'b0;
      sw_tick_q <= 1'b0;
    end else begin
      sw_start_q <= reg_wr && wr_hit(reg_addr, aste_pkg::ADDR_CTRL) &&
                    reg_wdata[aste_pkg::CTRL_SW_START];
      sw_tick_q <= reg_wr && wr_hit(reg_addr, aste_pkg::ADDR_CTRL) &&
                   reg_wdata[aste_pkg::CTRL_SW_TICK];
      if (reg_wr) begin
        unique case (reg_addr)
          aste_pkg::ADDR_CTRL: ctrl_q <= reg_wdata[6:2];
          aste_pkg::ADDR_SRC: src_q <= reg_wdata[5:0];
          aste_pkg::ADDR_DIV: div_q <= (reg_wdata == 32'h0000_0000) ? 32'h0000_0001 : reg_wdata;
          aste_pkg::ADDR_CHANS: chans_q <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
          aste_pkg::ADDR_PRE: pre_q <= reg_wdata;
          aste_pkg::ADDR_POST: post_q <= reg_wdata;
          aste_pkg::ADDR_MASK: mask_q <= reg_wdata[aste_pkg::STAT_W-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads, one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        aste_pkg::ADDR_CTRL: reg_rdata <= {25'h000_0000, ctrl_q, 2'b00};
        aste_pkg::ADDR_SRC: reg_rdata <= {26'h000_0000, src_q};
        aste_pkg::ADDR_DIV: reg_rdata <= div_q;
        aste_pkg::ADDR_CHANS: reg_rdata <= {24'h00_0000, chans_q};
        aste_pkg::ADDR_PRE: reg_rdata <= pre_q;
        aste_pkg::ADDR_POST: reg_rdata <= post_q;
        aste_pkg::ADDR_STAT: reg_rdata <= {29'h0000_0000, stat_q};
        aste_pkg::ADDR_MASK: reg_rdata <= {29'h0000_0000, mask_q};
        aste_pkg::ADDR_STATE: reg_rdata <= {22'h00_0000, conv_left_q, phase_q};
        aste_pkg::ADDR_COUNT: reg_rdata <= count_q;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Scan tick source
  // ----------------------------------------------------------------
  // timebase divider.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tb_q <= 1'b0;
      div_cnt_q <= 32'h0000_0000;
    end else begin
      tb_q <= scan_timebase;
      if (phase_q == aste_pkg::ASTE_IDLE) begin
        div_cnt_q <= 32'h0000_0000;
      end else if (scan_timebase && !tb_q) begin
        div_cnt_q <= (div_cnt_q + 32'h0000_0001 >= div_q) ? 32'h0000_0000 :
                     div_cnt_q + 32'h0000_0001;
      end
    end
  end
  assign div_tick = (div_cnt_q + 32'h0000_0001 >= div_q) ? 1'b1 : 1'b0;

  always_comb begin
    unique case (src_q.kind)
      aste_pkg::ASTE_SRC_COUNTER: raw_tick = counter_out;
      aste_pkg::ASTE_SRC_DIVIDER: raw_tick = div_tick && scan_timebase && !tb_q;
      aste_pkg::ASTE_SRC_SOFTWARE: raw_tick = sw_tick_q;
      aste_pkg::ASTE_SRC_EXTERNAL: raw_tick = (src_q.ext_line < 4'(aste_pkg::EXT_LINES)) ?
                                              ext_in[src_q.ext_line] : 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw_tick;
    end
  end
  assign edge_tick = ctrl_q[aste_pkg::CTRL_FALLING] ? (raw_q && !raw_tick) :
                     (raw_tick && !raw_q);

  // gate idle and hold; busy gate.
  assign busy = conv_left_q != 8'h00;
  assign tick_ok = edge_tick && phase_q != aste_pkg::ASTE_IDLE && !acq_hold_trigger && !busy;
  assign conv_ok = channel_conversion_tick && busy;
  assign start_ev = ctrl_q[aste_pkg::CTRL_ARM] && phase_q == aste_pkg::ASTE_IDLE &&
                    (sw_start_q || (ctrl_q[aste_pkg::CTRL_HW_START] && acq_begin_trigger));
  assign last_sample = count_q == 32'h0000_0001;

  // ----------------------------------------------------------------
  // Per-sample conversion pacing
  // ----------------------------------------------------------------
  // one conversion per channel; tick sets convert period.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_left_q <= 8'h00;
    end else if (tick_ok) begin
      conv_left_q <= chans_q;
    end else if (ctrl_q[aste_pkg::CTRL_ABORT]) begin
      // Going idle lets the final sample finish its conversions; only abort cuts them.
      conv_left_q <= 8'h00;
    end else if (conv_ok) begin
      conv_left_q <= conv_left_q - 8'h01;
    end
  end
  assign convert_start = conv_ok;
  assign sample_start = tick_ok;

  // ----------------------------------------------------------------
  // Sample counter and acquisition phases
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || ctrl_q[aste_pkg::CTRL_ABORT]) begin
      phase_q <= aste_pkg::ASTE_IDLE;
      count_q <= 32'h0000_0000;
    end else if (start_ev) begin
      if (ctrl_q[aste_pkg::CTRL_PRETRIG] && pre_q != 32'h0000_0000) begin
        phase_q <= aste_pkg::ASTE_PRE;
        count_q <= pre_q;
      end else if (ctrl_q[aste_pkg::CTRL_PRETRIG]) begin
        phase_q <= aste_pkg::ASTE_WAIT_REF;
        count_q <= post_q;
      end else begin
        phase_q <= aste_pkg::ASTE_POST;
        count_q <= post_q;
      end
    end else begin
      unique case (phase_q)
        aste_pkg::ASTE_IDLE: begin
        end
        aste_pkg::ASTE_PRE: begin
          if (tick_ok && last_sample) begin
            phase_q <= aste_pkg::ASTE_WAIT_REF;
            count_q <= post_q;
          end else if (tick_ok) begin
            count_q <= count_q - 32'h0000_0001;
          end
        end
        aste_pkg::ASTE_WAIT_REF: begin
          if (capture_ref_trigger) begin
            phase_q <= (post_q == 32'h0000_0000) ? aste_pkg::ASTE_IDLE : aste_pkg::ASTE_POST;
          end
        end
        aste_pkg::ASTE_POST: begin
          if (tick_ok && (last_sample || count_q == 32'h0000_0000)) begin
            phase_q <= aste_pkg::ASTE_IDLE;
            count_q <= 32'h0000_0000;
          end else if (tick_ok) begin
            count_q <= count_q - 32'h0000_0001;
          end
        end
      endcase
    end
  end
  assign acq_active = phase_q != aste_pkg::ASTE_IDLE;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acq_begin_trigger_out <= 1'b0;
    end else begin
      acq_begin_trigger_out <= start_ev && sw_start_q;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle, so no event is lost.
  always_comb begin
    stat_set = '0;
    stat_set[aste_pkg::STAT_DONE] = phase_q == aste_pkg::ASTE_POST && tick_ok &&
                                    (last_sample || count_q == 32'h0000_0000);
    stat_set[aste_pkg::STAT_OVERRUN] = edge_tick && busy && !acq_hold_trigger;
    // reference only counts in the waiting phase.
    stat_set[aste_pkg::STAT_REF_ACC] = phase_q == aste_pkg::ASTE_WAIT_REF && capture_ref_trigger;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_q <= '0;
    end else if (reg_wr && wr_hit(reg_addr, aste_pkg::ADDR_STAT)) begin
      stat_q <= (stat_q & ~reg_wdata[aste_pkg::STAT_W-1:0]) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end
  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // idle ignores ticks.
  idle_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
    phase_q == aste_pkg::ASTE_IDLE |-> !sample_start) else $error("tick taken while idle");
  busy_block_a: assert property (@(posedge core_clk) disable iff (reset)
    busy |-> !sample_start) else $error("tick taken during conversions");
  conv_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    convert_start |-> conv_left_q != 8'h00) else $error("stray conversion passed");
  chan_load_a: assert property (@(posedge core_clk) disable iff (reset)
    sample_start |=> conv_left_q == $past(chans_q)) else $error("channel count not loaded");
  post_load_a: assert property (@(posedge core_clk) disable iff (reset)
    start_ev && !ctrl_q[aste_pkg::CTRL_PRETRIG] && !ctrl_q[aste_pkg::CTRL_ABORT]
    |=> count_q == $past(post_q) && phase_q == aste_pkg::ASTE_POST) else $error("post count not loaded");
  pre_reload_a: assert property (@(posedge core_clk) disable iff (reset)
    phase_q == aste_pkg::ASTE_PRE && tick_ok && last_sample && !ctrl_q[aste_pkg::CTRL_ABORT]
    |=> phase_q == aste_pkg::ASTE_WAIT_REF && count_q == $past(post_q)) else $error("no post reload");
  ref_early_a: assert property (@(posedge core_clk) disable iff (reset)
    phase_q == aste_pkg::ASTE_PRE && !tick_ok && !ctrl_q[aste_pkg::CTRL_ABORT]
    |=> phase_q == aste_pkg::ASTE_PRE) else $error("early reference acted");
  sw_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    start_ev && sw_start_q |=> acq_begin_trigger_out ##1 !acq_begin_trigger_out)
    else $error("no start pulse");
  done_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    stat_set[aste_pkg::STAT_DONE] |=> stat_q[aste_pkg::STAT_DONE]) else $error("done flag lost");
  overrun_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    edge_tick && busy && !acq_hold_trigger |=> stat_q[aste_pkg::STAT_OVERRUN])
    else $error("overrun not flagged");

  post_run_c: cover property (@(posedge core_clk) disable iff (reset)
    phase_q == aste_pkg::ASTE_POST ##1 phase_q == aste_pkg::ASTE_IDLE);
  pre_run_c: cover property (@(posedge core_clk) disable iff (reset)
    phase_q == aste_pkg::ASTE_WAIT_REF ##1 phase_q == aste_pkg::ASTE_POST);
  overrun_c: cover property (@(posedge core_clk) disable iff (reset)
    stat_set[aste_pkg::STAT_OVERRUN]);

endmodule // aste_timing_engine

// [tb/aste_ext_source.sv]
// Model of the external tick lines and the conversion tick source.
`timescale 1ns/1ps
module aste_ext_source (
  input wire logic core_clk,
  input wire logic [3:0] line_idx,
  input wire logic line_go,
  input wire logic conv_go,
  input wire logic [7:0] conv_n,
  input wire logic [3:0] conv_gap,
  output aste_pkg::aste_ext_s ext_in,
  output logic channel_conversion_tick,
  output logic busy
);
  logic [14:0] lines_q = 15'h0000;
  logic [3:0] idx_q;
  logic busy_l = 1'b0;
  logic busy_c = 1'b0;
  logic conv_q = 1'b0;
  int k;
  // The lines are driven low between pulses, so no stale level lingers.
  assign channel_conversion_tick = conv_q;
  assign ext_in = lines_q;
  assign busy = busy_l | busy_c;

  // ----------------------------------------------------------------
  // Line pulses and conversion bursts
  // ----------------------------------------------------------------
  // external tick pulse.
  always @(posedge core_clk) begin
    if (line_go) begin
      busy_l <= 1'b1;
      idx_q = line_idx;
      lines_q[idx_q] <= 1'b1;
      repeat (2) @(posedge core_clk);
      lines_q[idx_q] <= 1'b0;
      repeat (2) @(posedge core_clk);
      busy_l <= 1'b0;
    end
  end

  // A nonzero gap makes the source answer slowly between conversions.
  always @(posedge core_clk) begin
    if (conv_go) begin
      busy_c <= 1'b1;
      for (k = 0; k < int'(conv_n); k++) begin
        conv_q <= 1'b1;
        @(posedge core_clk);
        conv_q <= 1'b0;
        repeat (1 + conv_gap) @(posedge core_clk);
      end
      busy_c <= 1'b0;
    end
  end
endmodule // aste_ext_source

// [tb/tb_top.sv]
// Self-checking bench for the analog-input sample timing engine.
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    aste_pkg::aste_src_e kind;
    logic fall;
    logic [3:0] idx;
    int div;
    int post;
    int chans;
  } aste_row_s;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic counter_out = 1'b0;
  logic scan_timebase = 1'b0;
  logic start_hw = 1'b0;
  logic ref_trig = 1'b0;
  logic hold = 1'b0;
  logic [3:0] line_idx = 4'h0;
  logic line_go = 1'b0;
  logic conv_go = 1'b0;
  logic [7:0] conv_n = 8'h00;
  logic [3:0] conv_gap = 4'h0;
  logic [31:0] reg_rdata;
  aste_pkg::aste_ext_s ext_in;
  logic conv_tick, pbusy, start_out, convert_start, sample_start, acq_active, irq;
  int mismatches = 0;
  int n_tests = 0;
  int n_samp = 0;
  int n_conv = 0;
  int n_bout = 0;
  logic [31:0] ctrl_v;
  logic [31:0] d;
  aste_row_s rows[7];

  aste_timing_engine dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_in(ext_in),
    .counter_out(counter_out), .scan_timebase(scan_timebase),
    .channel_conversion_tick(conv_tick), .acq_begin_trigger(start_hw),
    .capture_ref_trigger(ref_trig), .acq_hold_trigger(hold),
    .acq_begin_trigger_out(start_out), .convert_start(convert_start),
    .sample_start(sample_start), .acq_active(acq_active), .irq(irq)
  );
  aste_ext_source src (
    .core_clk(core_clk), .line_idx(line_idx), .line_go(line_go), .conv_go(conv_go),
    .conv_n(conv_n), .conv_gap(conv_gap), .ext_in(ext_in),
    .channel_conversion_tick(conv_tick), .busy(pbusy)
  );

  initial forever #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (!reset) begin
      n_samp <= n_samp + int'(sample_start === 1'b1);
      n_conv <= n_conv + int'(convert_start === 1'b1);
      n_bout <= n_bout + int'(start_out === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Bus, partner and checking tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] bit_of(input int b);
    return 32'h0000_0001 << b;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic far(input logic conv, input int n);
    int t;
    t = 0;
    @(posedge core_clk);
    conv_n <= 8'(n);
    line_idx <= 4'(n);
    conv_go <= conv;
    line_go <= !conv;
    @(posedge core_clk);
    conv_go <= 1'b0;
    line_go <= 1'b0;
    @(posedge core_clk);
    while (pbusy !== 1'b0 && t < 500) begin
      @(posedge core_clk);
      t++;
    end
    repeat (2) @(posedge core_clk);
  endtask
  task automatic pulse_ref();
    @(posedge core_clk);
    ref_trig <= 1'b1;
    @(posedge core_clk);
    ref_trig <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // The divider row runs at a division of two, hence two timebase pulses per tick.
  task automatic samp(input int kind, input logic [3:0] idx, input int chans);
    if (kind == 2) wr(aste_pkg::ADDR_CTRL, ctrl_v | bit_of(aste_pkg::CTRL_SW_TICK));
    else if (kind == 3) far(1'b0, int'(idx));
    else repeat (kind + 1) begin
      @(posedge core_clk);
      counter_out <= (kind == 0);
      scan_timebase <= (kind == 1);
      repeat (2) @(posedge core_clk);
      counter_out <= 1'b0;
      scan_timebase <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    if (chans > 0) far(1'b1, chans + 1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aste_row_s r;
    int s0, c0, b0;
    rows = '{'{aste_pkg::ASTE_SRC_COUNTER, 1'b0, 4'h0, 1, 2, 2},
      '{aste_pkg::ASTE_SRC_COUNTER, 1'b1, 4'h0, 1, 1, 3},
      '{aste_pkg::ASTE_SRC_DIVIDER, 1'b0, 4'h0, 2, 2, 1},
      '{aste_pkg::ASTE_SRC_SOFTWARE, 1'b0, 4'h0, 1, 3, 2},
      '{aste_pkg::ASTE_SRC_EXTERNAL, 1'b0, 4'h0, 1, 1, 1},
      '{aste_pkg::ASTE_SRC_EXTERNAL, 1'b1, 4'h4, 1, 2, 2},
      '{aste_pkg::ASTE_SRC_EXTERNAL, 1'b0, 4'he, 1, 1, 4}};
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd(aste_pkg::ADDR_DIV);
    chk(d, aste_pkg::RESET_DIV);
    rd(8'h30);
    chk(d, 32'h0000_0000);
    foreach (rows[i]) begin
      r = rows[i];
      conv_gap <= 4'(3 * (i % 2));
      wr(aste_pkg::ADDR_SRC, {26'h0, r.idx, r.kind});
      wr(aste_pkg::ADDR_DIV, 32'(r.div));
      wr(aste_pkg::ADDR_CHANS, 32'(r.chans));
      wr(aste_pkg::ADDR_POST, 32'(r.post));
      ctrl_v = bit_of(aste_pkg::CTRL_ARM) | (r.fall ? bit_of(aste_pkg::CTRL_FALLING) : 32'h0);
      s0 = n_samp;
      c0 = n_conv;
      b0 = n_bout;
      wr(aste_pkg::ADDR_CTRL, ctrl_v | bit_of(aste_pkg::CTRL_SW_START));
      far(1'b1, 1);
      repeat (r.post) samp(int'(r.kind), r.idx, r.chans);
      chk(32'(n_samp - s0), 32'(r.post));
      chk(32'(n_conv - c0), 32'(r.post * r.chans));
      chk(32'(n_bout - b0), 32'h1);
      rd(aste_pkg::ADDR_STAT);
      chk(d & 32'h1, 32'h1);
      chk({31'h0, acq_active}, 32'h0);
      wr(aste_pkg::ADDR_STAT, 32'h7);
    end
    // Ticks while idle, on hold or in mid-sample must be refused.
    s0 = n_samp;
    wr(aste_pkg::ADDR_SRC, {30'h0, aste_pkg::ASTE_SRC_SOFTWARE});
    wr(aste_pkg::ADDR_CHANS, 32'h1);
    wr(aste_pkg::ADDR_POST, 32'h3);
    wr(aste_pkg::ADDR_MASK, bit_of(aste_pkg::STAT_OVERRUN));
    ctrl_v = 32'h0;
    samp(2, 4'h0, 0);
    chk(32'(n_samp - s0), 32'h0);
    ctrl_v = bit_of(aste_pkg::CTRL_ARM);
    wr(aste_pkg::ADDR_CTRL, ctrl_v | bit_of(aste_pkg::CTRL_SW_START));
    samp(2, 4'h0, 0);
    samp(2, 4'h0, 0);
    chk(32'(n_samp - s0), 32'h1);
    rd(aste_pkg::ADDR_STAT);
    chk(d & 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    far(1'b1, 1);
    hold <= 1'b1;
    samp(2, 4'h0, 0);
    hold <= 1'b0;
    samp(2, 4'h0, 0);
    chk(32'(n_samp - s0), 32'h2);
    wr(aste_pkg::ADDR_STAT, bit_of(aste_pkg::STAT_OVERRUN));
    rd(aste_pkg::ADDR_STAT);
    chk({31'h0, irq}, 32'h0);
    chk(d & 32'h2, 32'h0);
    wr(aste_pkg::ADDR_CTRL, bit_of(aste_pkg::CTRL_ABORT));
    wr(aste_pkg::ADDR_CTRL, 32'h0);
    // Pretrigger run started by hardware, with a reference that comes too early.
    wr(aste_pkg::ADDR_PRE, 32'h2);
    wr(aste_pkg::ADDR_POST, 32'h2);
    ctrl_v = bit_of(aste_pkg::CTRL_ARM) | bit_of(aste_pkg::CTRL_PRETRIG);
    ctrl_v = ctrl_v | bit_of(aste_pkg::CTRL_HW_START);
    wr(aste_pkg::ADDR_CTRL, ctrl_v);
    s0 = n_samp;
    b0 = n_bout;
    @(posedge core_clk);
    start_hw <= 1'b1;
    @(posedge core_clk);
    start_hw <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, acq_active}, 32'h1);
    chk(32'(n_bout - b0), 32'h0);
    pulse_ref();
    rd(aste_pkg::ADDR_STATE);
    chk(d & 32'h3, 32'h1);
    rd(aste_pkg::ADDR_STAT);
    chk(d & 32'h4, 32'h0);
    repeat (2) samp(2, 4'h0, 1);
    rd(aste_pkg::ADDR_STATE);
    chk(d & 32'h3, 32'h2);
    samp(2, 4'h0, 1);
    pulse_ref();
    rd(aste_pkg::ADDR_STATE);
    chk(d & 32'h3, 32'h3);
    rd(aste_pkg::ADDR_STAT);
    chk(d & 32'h4, 32'h4);
    repeat (2) samp(2, 4'h0, 1);
    chk({31'h0, acq_active}, 32'h0);
    samp(2, 4'h0, 1);
    chk(32'(n_samp - s0), 32'h5);
    rd(aste_pkg::ADDR_STAT);
    chk(d & 32'h1, 32'h1);
    tally_and_finish();
  end
endmodule // tb_top
